// ==== pkg/wfim_consts.svh ====
`ifndef WFIM_CONSTS_SVH
`define WFIM_CONSTS_SVH

// ----------------------------------------------------------------
// register map (7-bit serial port addresses)
// ----------------------------------------------------------------
`define WFIM_ADDR_W           7
`define WFIM_OFS_ID_LOW_MASK  7'h35
`define WFIM_OFS_LEN_CODE     7'h36

// ----------------------------------------------------------------
// field positions and widths
// ----------------------------------------------------------------
`define WFIM_MASK_HI_MSB      15
`define WFIM_MASK_HI_LSB      8
`define WFIM_MASK_LO_MSB      6
`define WFIM_MASK_LO_LSB      2
`define WFIM_ID_BITS          13
`define WFIM_LEN_MSB          3
`define WFIM_LEN_MAX_BYTES    4'h8

// ----------------------------------------------------------------
// reset values
// ----------------------------------------------------------------
`define WFIM_MASK_RESET       13'h0000
`define WFIM_LEN_RESET        4'h0

// ----------------------------------------------------------------
// serial frame layout (bit counts)
// ----------------------------------------------------------------
`define WFIM_FRAME_BITS       6'h20
`define WFIM_HDR_BITS         6'h08
`define WFIM_DATA_BITS        5'h10

`endif

// ==== pkg/wfim_pkg.sv ====
// ----------------------------------------------------------------
// shared types of the wake frame mask block
// ----------------------------------------------------------------
package wfim_pkg;
    typedef logic [15:0] wfim_word_t;  // one register word
    typedef logic [6:0]  wfim_addr_t;  // serial register address
    typedef logic [12:0] wfim_id_t;    // low identifier slice
    typedef logic [3:0]  wfim_len_t;   // length code
endpackage : wfim_pkg

// ==== src/wfim_serial_port.sv ====
`timescale 1ns/1ps
`include "wfim_consts.svh"

// ----------------------------------------------------------------
// serial host port: 32-bit frames, mode 0, msb first
// frame = {write, addr[6:0], data[15:0], spare[7:0]}
// ----------------------------------------------------------------
module wfim_serial_port (
    input  wire logic                 clock,
    input  wire logic                 rst,
    input  wire logic                 spi_sck,   // raw pin
    input  wire logic                 spi_cs_n,  // raw pin, active low
    input  wire logic                 spi_mosi,  // raw pin
    input  wire wfim_pkg::wfim_word_t rd_data,   // view of addressed reg
    output logic                      spi_miso_q,
    output logic                      spi_miso_oe_q,
    output wfim_pkg::wfim_addr_t      addr_q,
    output wfim_pkg::wfim_word_t      wr_data_q,
    output logic                      wr_stb_q
);
    import wfim_pkg::*;

    // ------------------------------------------------------------
    // pin synchronisers: stage 1 feeds only stage 2
    // ------------------------------------------------------------
    logic [2:0] sck_q;   // [0] meta, [1] sync, [2] previous
    logic [2:0] cs_q;    // same layout for chip select
    logic [1:0] mosi_q;  // [0] meta, [1] sync

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            sck_q  <= 3'h0;
            cs_q   <= 3'h7;
            mosi_q <= 2'h0;
        end else begin
            sck_q  <= {sck_q[1], sck_q[0], spi_sck};
            cs_q   <= {cs_q[1], cs_q[0], spi_cs_n};
            mosi_q <= {mosi_q[0], spi_mosi};
        end
    end

    logic sck_rise;  // edge seen on synced clock pin
    logic sck_fall;
    logic cs_act;    // frame in progress
    logic cs_end;    // chip select released
    assign sck_rise = sck_q[1] & ~sck_q[2];
    assign sck_fall = ~sck_q[1] & sck_q[2];
    assign cs_act   = ~cs_q[1];
    assign cs_end   = cs_q[1] & ~cs_q[2];

    // ------------------------------------------------------------
    // receive shifter and bit counter
    // ------------------------------------------------------------
    logic [5:0]  cnt_q;    // bits received, saturates
    logic [23:0] rx_q;     // header and data bits
    logic        load_q;   // header complete, fetch read data

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            cnt_q  <= 6'h00;
            rx_q   <= 24'h000000;
            load_q <= 1'b0;
        end else begin
            load_q <= 1'b0;
            if (!cs_act) begin
                cnt_q <= 6'h00;  // idle between frames
            end else if (sck_rise) begin
                if (cnt_q < `WFIM_HDR_BITS + `WFIM_DATA_BITS) begin
                    rx_q <= {rx_q[22:0], mosi_q[1]};
                end
                if (cnt_q != 6'h3f) begin
                    cnt_q <= cnt_q + 6'h01;
                end
                load_q <= (cnt_q == `WFIM_HDR_BITS - 6'h01);
            end
        end
    end

    // address is taken once the header is in
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            addr_q <= 7'h00;
        end else if (load_q) begin
            addr_q <= rx_q[6:0];
        end
    end

    // ------------------------------------------------------------
    // transmit: read data goes out on falling edges after header
    // ------------------------------------------------------------
    logic [15:0] tx_q;     // read data shifter
    logic        tx_go_q;  // fetch one cycle after addr update

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            tx_q          <= 16'h0000;
            tx_go_q       <= 1'b0;
            spi_miso_q    <= 1'b0;
            spi_miso_oe_q <= 1'b0;
        end else begin
            tx_go_q       <= load_q;
            spi_miso_oe_q <= cs_act;  // driven only while selected
            if (tx_go_q) begin
                tx_q <= rd_data;
            end else if (sck_fall && cnt_q >= `WFIM_HDR_BITS) begin
                spi_miso_q <= tx_q[15];
                tx_q       <= {tx_q[14:0], 1'b0};
            end
            if (!cs_act) begin
                spi_miso_q <= 1'b0;
            end
        end
    end

    // ------------------------------------------------------------
    // write commits only for a complete frame, at release
    // ------------------------------------------------------------
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            wr_stb_q  <= 1'b0;
            wr_data_q <= 16'h0000;
        end else begin
            wr_stb_q <= 1'b0;
            if (cs_end && cnt_q == `WFIM_FRAME_BITS && rx_q[23]) begin
                wr_stb_q  <= 1'b1;
                wr_data_q <= rx_q[15:0];
            end
        end
    end
endmodule : wfim_serial_port

// ==== src/wfim_top.sv ====
// Behaviour
// - mask bit one: identifier bit is compared
// - mask bit zero: identifier bit is ignored
// - id bits 12..5 sit in bits 15..8
// - id bits 4..0 sit in bits 6..2
// - mask bits 7, 1:0 read zero, ignore writes
// - length code in 3:0, 15:4 read zero
// - codes 0..7 mean that many bytes
// - codes 8..15 all mean eight bytes
// - length code must match bit for bit
// - code zero means empty and cleared
`timescale 1ns/1ps
`include "wfim_consts.svh"

module wfim_top (
    input  wire logic                clock,
    input  wire logic                rst,        // power-on, async
    input  wire logic                soft_rst,   // sync pulse
    input  wire logic                restart,    // sync pulse
    input  wire logic                spi_sck,
    input  wire logic                spi_cs_n,
    input  wire logic                spi_mosi,
    input  wire logic                rx_valid,   // frame decoded pulse
    input  wire wfim_pkg::wfim_id_t  rx_id,      // received id 12..0
    input  wire wfim_pkg::wfim_len_t rx_len,     // received length code
    input  wire wfim_pkg::wfim_id_t  cfg_id,     // expected id 12..0
    output logic                     spi_miso_q,
    output logic                     spi_miso_oe_q,
    output logic                     id_match_q,
    output logic                     len_match_q,
    output logic                     match_done_q,
    output wfim_pkg::wfim_len_t      len_bytes_q
);
    import wfim_pkg::*;

    // checks below share this clock and are off during power-on reset
    default clocking cb @(posedge clock);
    endclocking
    default disable iff (rst);

    // ------------------------------------------------------------
    // host port
    // ------------------------------------------------------------
    wfim_addr_t addr;     // addressed register
    wfim_word_t wr_data;  // write word
    logic       wr_stb;   // one-cycle write commit
    wfim_word_t rd_view;  // read view of addressed register

    wfim_serial_port u_port (
        .clock         (clock),
        .rst           (rst),
        .spi_sck       (spi_sck),
        .spi_cs_n      (spi_cs_n),
        .spi_mosi      (spi_mosi),
        .rd_data       (rd_view),
        .spi_miso_q    (spi_miso_q),
        .spi_miso_oe_q (spi_miso_oe_q),
        .addr_q        (addr),
        .wr_data_q     (wr_data),
        .wr_stb_q      (wr_stb)
    );

    // ------------------------------------------------------------
    // configuration storage: only writable bits have flops
    // ------------------------------------------------------------
    wfim_id_t  mask_q;  // compare selects, id bit order
    wfim_len_t len_q;   // expected length code
    logic      wr_mask;
    logic      wr_len;
    assign wr_mask = wr_stb && addr == `WFIM_OFS_ID_LOW_MASK;
    assign wr_len  = wr_stb && addr == `WFIM_OFS_LEN_CODE;

    // mask register; restart leaves it alone
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            mask_q <= `WFIM_MASK_RESET;
        end else if (soft_rst) begin
            mask_q <= `WFIM_MASK_RESET;
        end else if (wr_mask) begin
            // reserved 7 and 1:0 dropped on write
            mask_q <= {wr_data[`WFIM_MASK_HI_MSB:`WFIM_MASK_HI_LSB],
                       wr_data[`WFIM_MASK_LO_MSB:`WFIM_MASK_LO_LSB]};
        end
    end

    // high selects land in id bit order
    a_mask_high: assert property (
        wr_mask && !soft_rst |=> mask_q[12:5] == $past(wr_data[15:8]))
        else $error("mask high field wrong");

    // length code; zero doubles as the cleared state
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            len_q <= `WFIM_LEN_RESET;
        end else if (soft_rst) begin
            len_q <= `WFIM_LEN_RESET;
        end else if (wr_len) begin
            len_q <= wr_data[`WFIM_LEN_MSB:0];
        end
    end

    // soft reset clears both, restart touches neither
    a_soft_clear: assert property (
        soft_rst |=> mask_q == 13'h0000 && len_q == 4'h0
        ##1 len_bytes_q == 4'h0)
        else $error("soft reset did not clear");
    a_restart_keep: assert property (
        restart && !soft_rst && !wr_stb |=> $stable(mask_q)
        && $stable(len_q))
        else $error("restart changed contents");

    // ------------------------------------------------------------
    // read view: reserved bits are constant zero, unmapped reads 0
    // ------------------------------------------------------------
    always_comb begin
        case (addr)
            `WFIM_OFS_ID_LOW_MASK:
                rd_view = {mask_q[12:5], 1'b0, mask_q[4:0], 2'b00};
            `WFIM_OFS_LEN_CODE:
                rd_view = {12'h000, len_q};
            default:
                rd_view = 16'h0000;
        endcase
    end

    // read view after a write, reserved positions always zero
    a_mask_low: assert property (
        wr_mask && !soft_rst ##1 addr == `WFIM_OFS_ID_LOW_MASK
        |-> rd_view[6:2] == $past(wr_data[6:2]))
        else $error("mask low field wrong");
    a_mask_reserved: assert property (
        addr == `WFIM_OFS_ID_LOW_MASK |-> rd_view[7] == 1'b0
        && rd_view[1:0] == 2'b00)
        else $error("mask reserved bits not zero");
    a_len_reserved: assert property (
        wr_len && !soft_rst ##1 addr == `WFIM_OFS_LEN_CODE
        |-> rd_view == {12'h000, $past(wr_data[3:0])})
        else $error("length register read wrong");

    // ------------------------------------------------------------
    // frame compare: one result per received frame
    // ------------------------------------------------------------
    wfim_id_t bit_ok;  // per identifier bit pass
    genvar gi;
    generate
        for (gi = 0; gi < `WFIM_ID_BITS; gi = gi + 1) begin : g_cmp
            // selected bits must equal, deselected always pass
            assign bit_ok[gi] = mask_q[gi] ? (rx_id[gi] == cfg_id[gi])
                                           : 1'b1;
        end
    endgenerate

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            id_match_q   <= 1'b0;
            len_match_q  <= 1'b0;
            match_done_q <= 1'b0;
        end else begin
            match_done_q <= rx_valid;
            if (rx_valid) begin
                id_match_q  <= &bit_ok;
                // raw code compare, so 9 never matches 8
                len_match_q <= (rx_len == len_q);
            end
        end
    end

    // one result per frame, a cycle after the valid strobe
    a_id_compared: assert property (
        rx_valid && ((rx_id ^ cfg_id) & mask_q) != 13'h0000
        |=> !id_match_q && match_done_q)
        else $error("selected id mismatch not rejected");
    a_id_ignored: assert property (
        rx_valid && ((rx_id ^ cfg_id) & mask_q) == 13'h0000
        |=> id_match_q)
        else $error("ignored id bits caused reject");
    a_len_exact: assert property (
        rx_valid |=> len_match_q == ($past(rx_len) == $past(len_q)))
        else $error("length code compare wrong");

    // decoded payload size of the configured code
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            len_bytes_q <= 4'h0;
        end else if (len_q[3]) begin
            len_bytes_q <= `WFIM_LEN_MAX_BYTES;
        end else begin
            len_bytes_q <= len_q;
        end
    end

    // decoded size follows the code one cycle later
    a_len_small: assert property (
        len_q < 4'h8 && $stable(len_q) |=> len_bytes_q == $past(len_q))
        else $error("short length decode wrong");
    a_len_big: assert property (
        len_q >= 4'h8 |=> len_bytes_q == 4'h8)
        else $error("long length decode wrong");

endmodule : wfim_top

// ==== testbench/wfim_can_node.sv ====
`timescale 1ns/1ps

// ----------------------------------------------------------------
// far-side model: a bus node whose decoded frames reach the filter
// ----------------------------------------------------------------
module wfim_can_node (
    input  wire logic           clock,
    output logic                rx_valid,
    output wfim_pkg::wfim_id_t  rx_id,
    output wfim_pkg::wfim_len_t rx_len
);
    import wfim_pkg::*;

    // quiet bus at time zero
    initial begin
        rx_valid = 1'b0;
        rx_id    = 13'h0000;
        rx_len   = 4'h0;
    end

    // one decoded frame; fields inverted afterwards so that a stale
    // value can never pass for a fresh match
    task automatic send(input wfim_id_t id, input wfim_len_t len);
        @(posedge clock);
        #1;
        rx_valid = 1'b1;
        rx_id    = id;
        rx_len   = len;
        @(posedge clock);
        #1;
        rx_valid = 1'b0;
        rx_id    = ~id;
        rx_len   = ~len;
    endtask : send
endmodule : wfim_can_node

// ==== testbench/wake_frame_id_mask_dlc_bench.sv ====
`timescale 1ns/1ps
`include "wfim_consts.svh"

module wake_frame_id_mask_dlc_bench;
    import wfim_pkg::*;

    // ----------------------------------------------------------------
    // signals
    // ----------------------------------------------------------------
    logic       clock, rst, soft_rst, restart;    // clock and resets
    logic       spi_sck, spi_cs_n, spi_mosi;      // host pins
    logic       spi_miso_q, spi_miso_oe_q;        // host data out
    logic       id_match_q, len_match_q;          // compare results
    logic       match_done_q;                     // result strobe
    logic       rx_valid;                         // from bus node
    wfim_id_t   rx_id, cfg_id;                    // received, expected
    wfim_len_t  rx_len, len_bytes_q;              // length code, decoded bytes
    wfim_word_t rd;                               // last read word
    int         fail_count, total_checks;         // report counters

    // 125 MHz
    always #4 clock = ~clock;

    wfim_top dut (
        .clock(clock), .rst(rst), .soft_rst(soft_rst),
        .restart(restart), .spi_sck(spi_sck), .spi_cs_n(spi_cs_n),
        .spi_mosi(spi_mosi), .rx_valid(rx_valid), .rx_id(rx_id),
        .rx_len(rx_len), .cfg_id(cfg_id), .spi_miso_q(spi_miso_q),
        .spi_miso_oe_q(spi_miso_oe_q), .id_match_q(id_match_q),
        .len_match_q(len_match_q), .match_done_q(match_done_q),
        .len_bytes_q(len_bytes_q)
    );

    wfim_can_node node (
        .clock(clock), .rx_valid(rx_valid), .rx_id(rx_id),
        .rx_len(rx_len)
    );

    // ----------------------------------------------------------------
    // helpers
    // ----------------------------------------------------------------
    // let n edges pass, then step just past the last one
    task automatic ticks(input int n);
        repeat (n) @(posedge clock);
        #1;
    endtask : ticks

    task automatic check(input string what, input logic [15:0] exp,
                         input logic [15:0] got);
        total_checks++;
        if (got !== exp) begin
            fail_count++;
            $display("wrong value %s expected %h seen %h", what, exp, got);
        end
    endtask : check

    task automatic stop_test;
        $display("checks %0d mismatches %0d", total_checks, fail_count);
        if (fail_count == 0 && total_checks > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask : stop_test

    // serial frame; half periods of 8 clocks keep clear of the two-flop
    // synchronisers, miso is taken late in the high phase
    task automatic xfer(input logic wr, input wfim_addr_t a,
                        input wfim_word_t d, input int nbits,
                        output wfim_word_t q);
        logic [31:0] f;
        f = {wr, a, d, 8'h00};
        q = 16'h0000;
        spi_cs_n = 1'b0;
        for (int i = 0; i < nbits; i++) begin
            spi_mosi = f[31 - i];
            ticks(8);
            if (i == 0) begin
                check("miso enable", 16'h0001, {15'h0000, spi_miso_oe_q});
            end
            spi_sck = 1'b1;
            ticks(8);
            if (i >= 8 && i < 24) begin
                q = {q[14:0], spi_miso_q};
            end
            spi_sck = 1'b0;
        end
        ticks(8);
        spi_cs_n = 1'b1;
        spi_mosi = ~spi_mosi;  // deselected: data line no longer valid
        ticks(12);             // write lands and len_bytes follows
        check("miso release", 16'h0000,
              {14'h0000, spi_miso_oe_q, spi_miso_q});
    endtask : xfer

    task automatic wr_reg(input wfim_addr_t a, input wfim_word_t d);
        xfer(1'b1, a, d, 32, rd);
    endtask : wr_reg

    task automatic rd_chk(input string what, input wfim_addr_t a,
                          input wfim_word_t exp);
        xfer(1'b0, a, 16'h0000, 32, rd);
        check(what, exp, rd);
    endtask : rd_chk

    // one received frame; results are read during the strobe, which stands for exactly one cycle
    task automatic frame(input wfim_id_t id, input wfim_len_t len,
                         input logic exp_id, input logic exp_len);
        node.send(id, len);
        check("match strobe", 16'h0001, {15'h0000, match_done_q});
        check("id match", {15'h0000, exp_id}, {15'h0000, id_match_q});
        check("len match", {15'h0000, exp_len}, {15'h0000, len_match_q});
        ticks(1);
        check("strobe end", 16'h0000, {15'h0000, match_done_q});
    endtask : frame

    // compare selects of identifier bits 12..0 in register positions
    function automatic wfim_word_t mask_word(input wfim_id_t m);
        return {m[12:5], 1'b0, m[4:0], 2'b00};
    endfunction : mask_word

    // ----------------------------------------------------------------
    // hang guard
    // ----------------------------------------------------------------
    initial begin
        repeat (100000) @(posedge clock);
        fail_count++;
        stop_test();
    end

    // ----------------------------------------------------------------
    // main sequence
    // ----------------------------------------------------------------
    initial begin
        clock = 1'b0; rst = 1'b1; soft_rst = 1'b0; restart = 1'b0;
        spi_sck = 1'b0; spi_cs_n = 1'b1; spi_mosi = 1'b0;
        cfg_id = 13'h0a5a; fail_count = 0; total_checks = 0;
        ticks(16);
        rst = 1'b0;
        ticks(4);
        check("idle miso", 16'h0000, {14'h0, spi_miso_oe_q, spi_miso_q});
        rd_chk("mask reset", `WFIM_OFS_ID_LOW_MASK, 16'h0000);
        rd_chk("len reset", `WFIM_OFS_LEN_CODE, 16'h0000);
        wr_reg(`WFIM_OFS_ID_LOW_MASK, 16'hffff);
        rd_chk("mask spare", `WFIM_OFS_ID_LOW_MASK, 16'hff7c);
        wr_reg(`WFIM_OFS_LEN_CODE, 16'hffff);
        rd_chk("len spare", `WFIM_OFS_LEN_CODE, 16'h000f);
        wr_reg(7'h37, 16'hffff);
        rd_chk("unmapped", 7'h37, 16'h0000);
        xfer(1'b1, `WFIM_OFS_ID_LOW_MASK, 16'h0000, 31, rd);
        rd_chk("short frame", `WFIM_OFS_ID_LOW_MASK, 16'hff7c);
        // one select at a time: its bit counts, its neighbour does not
        for (int k = 0; k < 13; k++) begin
            wr_reg(`WFIM_OFS_ID_LOW_MASK, mask_word(13'h0001 << k));
            rd_chk("mask place", `WFIM_OFS_ID_LOW_MASK,
                   mask_word(13'h0001 << k));
            frame(cfg_id ^ (13'h0001 << k), 4'h0, 1'b0, 1'b0);
            frame(cfg_id ^ (13'h0001 << ((k + 1) % 13)), 4'h0,
                  1'b1, 1'b0);
        end
        // every code; the neighbour code c^1 must not match, even where both mean eight bytes
        wr_reg(`WFIM_OFS_ID_LOW_MASK, 16'hff7c);
        for (int c = 0; c < 16; c++) begin
            wr_reg(`WFIM_OFS_LEN_CODE, {12'hfff, c[3:0]});
            check("len bytes", (c > 8) ? 16'h0008 : 16'(c),
                  {12'h000, len_bytes_q});
            frame(cfg_id, c[3:0], 1'b1, 1'b1);
            frame(cfg_id, c[3:0] ^ 4'h1, 1'b1, 1'b0);
        end
        restart = 1'b1;
        ticks(1);
        restart = 1'b0;
        ticks(2);
        rd_chk("restart mask", `WFIM_OFS_ID_LOW_MASK, 16'hff7c);
        rd_chk("restart len", `WFIM_OFS_LEN_CODE, 16'h000f);
        soft_rst = 1'b1;
        ticks(1);
        soft_rst = 1'b0;
        ticks(2);
        rd_chk("soft mask", `WFIM_OFS_ID_LOW_MASK, 16'h0000);
        rd_chk("soft len", `WFIM_OFS_LEN_CODE, 16'h0000);
        check("len cleared", 16'h0000, {12'h000, len_bytes_q});
        frame(~cfg_id, 4'h0, 1'b1, 1'b1);
        stop_test();
    end
endmodule : wake_frame_id_mask_dlc_bench
